/* File: logic/watchdog_second_status_reg.sv */
// Watchdog second status register with reboot control
`timescale 1ns/1ps
`default_nettype none
module watchdog_second_status_reg
(
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    rtc_well_reset_n_i,
    input  wire wdt_status_pkg::reg_req_s reg_req_i,
    output logic [15:0]                  reg_rdata_o,
    input  wire logic                    mgmt_link_smi_msg_i,
    input  wire logic                    timer_zero_i,
    input  wire logic                    first_timeout_clear_i,
    input  wire logic                    cpu_first_fetch_i,
    input  wire logic                    no_reboot_i,
    input  wire logic [3:0]              cpu_multiplier_i,
    input  wire logic                    intrusion_pin_i,
    output logic                         first_timeout_o,
    output logic                         pci_bus_reset_n_o,
    output logic [3:0]                   freq_multiplier_o
);
    import wdt_status_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr);
        hit = (addr == STATUS_OFFSET);
    endfunction

    logic        wr_hit;
    logic        rd_hit;
    logic [15:0] w1c;
    assign wr_hit = reg_req_i.wr && hit(reg_req_i.addr);
    assign rd_hit = reg_req_i.rd && hit(reg_req_i.addr);
    assign w1c    = wr_hit ? reg_req_i.wdata : 16'h0000;

    // ------------------------------------------------------------
    // Resume-well flags
    // ------------------------------------------------------------
    logic          smi_r, smi_nxt;
    logic          second_r, second_nxt;
    logic          boot_r, boot_nxt;
    logic          first_r, first_nxt;
    logic          first_pulse_r, first_pulse_nxt;
    logic          second_evt;
    logic          second_rise;
    assign second_evt  = timer_zero_i && first_r;
    assign second_rise = second_evt && !second_r;

    always_comb
    begin
        // First expiry arms the second detection
        first_nxt       = first_r;
        first_pulse_nxt = 1'b0;
        if (first_timeout_clear_i)
            first_nxt = 1'b0;
        if (timer_zero_i && !first_r)
        begin
            first_nxt       = 1'b1;
            first_pulse_nxt = 1'b1;
        end
        smi_nxt = (smi_r && !w1c[SMI_FLAG_BIT]) || mgmt_link_smi_msg_i;
        second_nxt = (second_r && !w1c[SECOND_TO_BIT]) || second_evt;
        boot_nxt = (boot_r && !w1c[BOOT_FAIL_BIT])
                   || (second_rise && !cpu_first_fetch_i);
    end

    // Only the resume-well reset clears these; no PCI reset input
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            smi_r         <= STATUS_RESET[SMI_FLAG_BIT];
            second_r      <= STATUS_RESET[SECOND_TO_BIT];
            boot_r        <= STATUS_RESET[BOOT_FAIL_BIT];
            first_r       <= 1'b0;
            first_pulse_r <= 1'b0;
        end
        else
        begin
            smi_r         <= smi_nxt;
            second_r      <= second_nxt;
            boot_r        <= boot_nxt;
            first_r       <= first_nxt;
            first_pulse_r <= first_pulse_nxt;
        end
    end
    assign first_timeout_o = first_pulse_r;

    // ------------------------------------------------------------
    // RTC-well intrusion flag
    // ------------------------------------------------------------
    logic [2:0] intr_sync_r, intr_sync_nxt;
    logic       intr_lvl_r, intr_lvl_nxt;
    logic       intr_r, intr_nxt;

    always_comb
    begin
        intr_sync_nxt = {intr_sync_r[1:0], intrusion_pin_i};
        intr_lvl_nxt  = intr_lvl_r;
        if (intr_sync_r[1] == intr_sync_r[2])
            intr_lvl_nxt = intr_sync_r[2];
        intr_nxt = (intr_r && !w1c[INTRUSION_BIT])
                   || (intr_lvl_nxt && !intr_lvl_r);
    end

    // Only the RTC-well reset reaches this group
    always_ff @(posedge ref_clk_i or negedge rtc_well_reset_n_i)
    begin
        if (!rtc_well_reset_n_i)
        begin
            intr_sync_r <= 3'h0;
            intr_lvl_r  <= 1'b0;
            intr_r      <= STATUS_RESET[INTRUSION_BIT];
        end
        else
        begin
            intr_sync_r <= intr_sync_nxt;
            intr_lvl_r  <= intr_lvl_nxt;
            intr_r      <= intr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Reboot sequencer
    // ------------------------------------------------------------
    reboot_state_e            state_r, state_nxt;
    logic [PULSE_CNT_W-1:0]   cnt_r, cnt_nxt;
    logic                     pci_n_r, pci_n_nxt;
    logic [3:0]               mult_r, mult_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        pci_n_nxt = 1'b1;
        mult_nxt  = cpu_multiplier_i;
        case (state_r)
            RUN_ST:
            begin
                if (second_rise && !no_reboot_i)
                begin
                    state_nxt = REBOOT_ST;
                    cnt_nxt   = PULSE_CNT_W'(REBOOT_CYCLES - 1);
                    pci_n_nxt = 1'b0;
                    if (boot_nxt)
                        mult_nxt = SAFE_MULTIPLIER;
                end
            end
            REBOOT_ST:
            begin
                if (cnt_r == '0)
                    state_nxt = RUN_ST;
                else
                begin
                    cnt_nxt   = cnt_r - 1'b1;
                    pci_n_nxt = 1'b0;
                    if (boot_r)
                        mult_nxt = SAFE_MULTIPLIER;
                end
            end
            default:
                state_nxt = RUN_ST;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= RUN_ST;
            cnt_r   <= '0;
            pci_n_r <= 1'b1;
            mult_r  <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            pci_n_r <= pci_n_nxt;
            mult_r  <= mult_nxt;
        end
    end
    assign pci_bus_reset_n_o = pci_n_r;
    assign freq_multiplier_o = mult_r;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [15:0] rdata_r, rdata_nxt;

    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (rd_hit)
        begin
            rdata_nxt[SMI_FLAG_BIT]  = smi_r;
            rdata_nxt[BOOT_FAIL_BIT] = boot_r;
            rdata_nxt[SECOND_TO_BIT] = second_r;
            rdata_nxt[INTRUSION_BIT] = intr_r;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_r <= STATUS_RESET;
        else
            rdata_r <= rdata_nxt;
    end
    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_smi_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        mgmt_link_smi_msg_i |=> smi_r)
        else $error("SMI flag not set");
    a_smi_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        w1c[SMI_FLAG_BIT] && !mgmt_link_smi_msg_i |=> !smi_r)
        else $error("SMI flag not cleared");
    a_boot_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        second_rise && !cpu_first_fetch_i |=> boot_r && second_r)
        else $error("Boot flag not set");
    a_boot_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        w1c[BOOT_FAIL_BIT] && !second_rise |=> !boot_r)
        else $error("Boot flag not cleared");
    a_second_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        timer_zero_i && first_r |=> second_r)
        else $error("Second timeout not flagged");
    a_first_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        timer_zero_i && !first_r |=> first_timeout_o)
        else $error("First timeout not pulsed");
    a_second_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        w1c[SECOND_TO_BIT] && !second_evt |=> !second_r)
        else $error("Second timeout not cleared");
    a_reboot_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        second_rise && !no_reboot_i |=> !pci_bus_reset_n_o [*8])
        else $error("Reboot reset not held");
    a_safe_mult: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !pci_bus_reset_n_o && $past(boot_nxt) && $past(second_rise)
        |-> freq_multiplier_o == SAFE_MULTIPLIER)
        else $error("Safe multiplier not applied");
    a_intr_hold: assert property (@(posedge ref_clk_i)
        disable iff (!rtc_well_reset_n_i)
        intr_r && !w1c[INTRUSION_BIT] |=> intr_r)
        else $error("Intrusion flag lost");
    a_intr_set: assert property (@(posedge ref_clk_i)
        disable iff (!rtc_well_reset_n_i)
        $rose(intr_lvl_r) |-> intr_r)
        else $error("Intrusion flag not set");
    a_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_rdata_o[15:5] == 11'h000 && !reg_rdata_o[3])
        else $error("Reserved bits not zero");
endmodule
`default_nettype wire

/* File: logic/wdt_status_pkg.sv */
// Constants and types for the watchdog second status register
package wdt_status_pkg;
    localparam logic [7:0]  STATUS_OFFSET    = 8'h06;
    localparam logic [15:0] STATUS_RESET     = 16'h0000;
    localparam int          INTRUSION_BIT    = 0;
    localparam int          SECOND_TO_BIT    = 1;
    localparam int          BOOT_FAIL_BIT    = 2;
    localparam int          SMI_FLAG_BIT     = 4;
    localparam logic [3:0]  SAFE_MULTIPLIER  = 4'hF;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          REBOOT_PULSE_NS  = 1000;
    localparam int          REBOOT_CYCLES    =
        (REBOOT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PULSE_CNT_W      = 8;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_s;

    typedef enum logic {
        RUN_ST,
        REBOOT_ST
    } reboot_state_e;
endpackage

/* File: test/host_model.sv */
// Host software model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model
    import wdt_status_pkg::*;
(
    input  wire logic    clk_i,
    output var reg_req_s req_o
);
    initial req_o = '0;
    // ------------------------------------------------
    // One strobe, held for exactly one edge
    // ------------------------------------------------
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [15:0] d);
        @(posedge clk_i);
        #1;
        req_o = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        req_o = '0;
    endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the watchdog second status register
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %h got %h", nm, e, g); \
    bad_count++; end end
module testbench;
    import wdt_status_pkg::*;
    typedef struct packed {
        logic        smi;
        logic        intr;
        logic [15:0] wd;
        logic [15:0] exp;
    } row_s;
    logic        ref_clk_i = 0, rst_i = 1, rtc_n = 0, smi = 0, tz = 0;
    logic        ftc = 0, fetch = 0, noreb = 0, intr = 0, ft_o, pci_n;
    logic [15:0] rdata;
    logic [3:0]  mult;
    logic [3:0]  cmul = 4'h5;
    reg_req_s    req;
    int          bad_count = 0, checks_done = 0, cyc = 0;
    row_s        rows [4] = '{'{1, 0, 16'h0000, 16'h0010},
                              '{0, 0, 16'h0010, 16'h0000},
                              '{0, 1, 16'h0000, 16'h0001},
                              '{0, 0, 16'hFFFF, 16'h0000}};
    host_model u_host (.clk_i(ref_clk_i), .req_o(req));
    watchdog_second_status_reg dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .rtc_well_reset_n_i(rtc_n),
        .reg_req_i(req), .reg_rdata_o(rdata), .mgmt_link_smi_msg_i(smi),
        .timer_zero_i(tz), .first_timeout_clear_i(ftc),
        .cpu_first_fetch_i(fetch), .no_reboot_i(noreb),
        .cpu_multiplier_i(cmul), .intrusion_pin_i(intr),
        .first_timeout_o(ft_o), .pci_bus_reset_n_o(pci_n),
        .freq_multiplier_o(mult));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic pulse(ref logic s);
        @(posedge ref_clk_i);
        #1;
        s = 1;
        @(posedge ref_clk_i);
        #1;
        s = 0;
    endtask
    task automatic wr(input logic [15:0] d);
        u_host.access(1, STATUS_OFFSET, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        u_host.access(0, a, 16'h0000);
        `CHK("status", e, rdata)
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            end_sim();
        end
    end
    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        #1;
        rst_i = 0;
        rtc_n = 1;
        rd(STATUS_OFFSET, 16'h0000);
        foreach (rows[i])
        begin
            if (rows[i].smi) pulse(smi);
            intr = rows[i].intr;
            repeat (6) @(posedge ref_clk_i);
            if (rows[i].wd != 0) wr(rows[i].wd);
            rd(STATUS_OFFSET, rows[i].exp);
        end
        pulse(smi);
        intr = 1;
        repeat (6) @(posedge ref_clk_i);
        #1;
        intr = 0;
        u_host.access(1, 8'h07, 16'hFFFF);
        rd(8'h07, 16'h0000);
        pulse(rst_i);
        rd(STATUS_OFFSET, 16'h0001);
        @(posedge ref_clk_i);
        #1;
        rtc_n = 0;
        @(posedge ref_clk_i);
        #1;
        rtc_n = 1;
        rd(STATUS_OFFSET, 16'h0000);
        pulse(ftc);
        pulse(tz);
        `CHK("first", 1'b1, ft_o)
        pulse(tz);
        `CHK("pci", 1'b0, pci_n)
        `CHK("mult", 4'hF, mult)
        rd(STATUS_OFFSET, 16'h0006);
        repeat (100) @(posedge ref_clk_i);
        #1;
        `CHK("pci", 1'b1, pci_n)
        `CHK("mult", 4'h5, mult)
        wr(16'h0002);
        wr(16'h0004);
        rd(STATUS_OFFSET, 16'h0000);
        fetch = 1;
        noreb = 1;
        pulse(tz);
        `CHK("pci", 1'b1, pci_n)
        rd(STATUS_OFFSET, 16'h0002);
        cmul = 4'hA;
        repeat (2) @(posedge ref_clk_i);
        #1;
        `CHK("mult", 4'hA, mult)
        end_sim();
    end
endmodule
`default_nettype wire
